// >>> latch_ack_pkg.sv
// Package for the latch and acknowledge manager: sizes, register map, field layouts.
// Assumes a single clock domain and a plain strobe register port.
package latch_ack_pkg;

  // Default item counts.
  localparam int NUM_LAMPS  = 8;
  localparam int NUM_RELAYS = 8;
  localparam int NUM_TELEM  = 8;

  // Relay off-delay: time in ns and derived cycle count at 200 MHz.
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int RELAY_OFF_NS     = 100;
  localparam int RELAY_OFF_CYCLES = (RELAY_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OFF_CNT_W        = 16;

  // Register offsets (byte addresses, one word each).
  localparam logic [7:0] REG_LATCH_EN   = 8'h00;
  localparam logic [7:0] REG_AUTO_ACK   = 8'h04;
  localparam logic [7:0] REG_CONTROL    = 8'h08;
  localparam logic [7:0] REG_COMMAND    = 8'h0c;
  localparam logic [7:0] REG_LAMP_STAT  = 8'h10;
  localparam logic [7:0] REG_RELAY_STAT = 8'h14;
  localparam logic [7:0] REG_TELEM_STAT = 8'h18;
  localparam logic [7:0] REG_TRIP_STAT  = 8'h1c;

  // Field positions inside REG_LATCH_EN.
  localparam int LEN_LAMP_POS  = 0;
  localparam int LEN_RELAY_POS = 8;
  localparam int LEN_TELEM_POS = 16;
  localparam int LEN_TRIP_POS  = 24;

  // Field positions inside REG_CONTROL.
  localparam int CTL_REMOTE_POS = 0;
  localparam int CTL_KEY_LO     = 4;

  // Reset values.
  localparam logic [31:0] LATCH_EN_RST = 32'h0000_0000;
  localparam logic [7:0]  AUTO_ACK_RST = 8'h00;
  localparam logic        REMOTE_RST   = 1'b0;
  localparam logic [2:0]  KEY_SEL_RST  = 3'h1;

  // Command bits in REG_COMMAND (write one to execute).
  localparam int CMD_LAMPS = 0;
  localparam int CMD_RELAY = 1;
  localparam int CMD_TELEM = 2;
  localparam int CMD_TRIP  = 3;
  localparam int CMD_ALL   = 4;

  // Panel key scope selection.
  typedef enum logic [2:0] {
    KEY_NOTHING    = 3'h0,
    KEY_LAMPS_FREE = 3'h1,
    KEY_LAMPS      = 3'h2,
    KEY_LAMPS_RLY  = 3'h3,
    KEY_ALL        = 3'h4
  } key_scope_t;

  // One acknowledge request across the four item groups.
  typedef struct packed {
    logic lamps;
    logic relays;
    logic telem;
    logic trip;
  } ack_set_t;

  // Register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// >>> latch_acknowledge_manager.sv
// Latch and acknowledge manager for lamps, output relays, telemetry signals and trip.
// Assumes sources and acknowledge pins are asynchronous; the register port is synchronous.
// Assumes a register master that keeps each write or read strobe to a single cycle.
//
// Overview of operation
// - Each output type has a latching option.
// - Acknowledge clears only once source is inactive.
// - Remote disabled: only panel key acknowledges.
// - Released relay waits for its off-delay.
// - New alarm clears lamps with auto-acknowledge.
// - Auto acknowledge never touches relays, telemetry, trip.
// - Individual input clears its own item.
// - Group input clears its whole group.
// - Lamp group input clears all lamps.
// - Collective commands clear their fixed sets.
// - Panel key acts as collective acknowledge.
// - Remote disabled blocks external and telemetry commands.
// - Relay and telemetry group inputs exist.
`timescale 1ns/1ps
`default_nettype none

module latch_acknowledge_manager
  import latch_ack_pkg::*;
#(
  parameter int NL = latch_ack_pkg::NUM_LAMPS,
  parameter int NR = latch_ack_pkg::NUM_RELAYS,
  parameter int NT = latch_ack_pkg::NUM_TELEM,
  parameter int OFF_CYCLES = latch_ack_pkg::RELAY_OFF_CYCLES
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire latch_ack_pkg::reg_req_t  reg_req_in,
  output logic [31:0]                   reg_rdata_out,
  input  wire logic [NL-1:0]            lamp_src_in,
  input  wire logic [NR-1:0]            relay_src_in,
  input  wire logic [NT-1:0]            telem_src_in,
  input  wire logic                     trip_src_in,
  input  wire logic                     prot_alarm_in,
  input  wire logic [NL-1:0]            lamp_ack_in,
  input  wire logic [NR-1:0]            relay_ack_in,
  input  wire logic [NT-1:0]            telem_ack_in,
  input  wire logic                     trip_command_ack_input_in,
  input  wire logic                     lamp_group_ack_input_in,
  input  wire logic                     relay_group_ack_input_in,
  input  wire logic                     telem_group_ack_input_in,
  input  wire logic                     panel_key_in,
  output logic [NL-1:0]                 lamp_out,
  output logic [NR-1:0]                 relay_out,
  output logic [NT-1:0]                 telem_out,
  output logic                          trip_out
);
  import latch_ack_pkg::*;

  localparam int NI = NL + NR + NT + 1 + 5;  // Sources, then alarm, the three group pins and the panel key.

  // Three-stage synchronisers; the first stage feeds only the second.
  // Every source and acknowledge pin is treated as asynchronous to the core clock, so
  // a level reaches the latch logic about four cycles after it changes at the pin.
  // The price is a short delay on every lamp and relay, which is far below any
  // protection timing and buys freedom from metastable decisions in the latches.
  logic [NI-1:0] sync1;
  logic [NI-1:0] sync2;
  logic [NI-1:0] sync3;
  logic [NI-1:0] filt;
  logic [NI-1:0] filt_q;
  logic [NL+NR+NT:0] ack_sync1;
  logic [NL+NR+NT:0] ack_sync2;
  logic [NL+NR+NT:0] ack_sync3;
  logic [NL+NR+NT:0] ack_filt;
  logic [NL+NR+NT:0] ack_filt_q;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      ack_sync1 <= '0;
      ack_sync2 <= '0;
      ack_sync3 <= '0;
    end else begin
      sync1     <= {panel_key_in, telem_group_ack_input_in, relay_group_ack_input_in,
                    lamp_group_ack_input_in, prot_alarm_in, trip_src_in, telem_src_in,
                    relay_src_in, lamp_src_in};
      sync2     <= sync1;
      sync3     <= sync2;
      ack_sync1 <= {trip_command_ack_input_in, telem_ack_in, relay_ack_in, lamp_ack_in};
      ack_sync2 <= ack_sync1;
      ack_sync3 <= ack_sync2;
    end
  end

  // A change is accepted only when stages two and three agree, which rejects one-cycle glitches.
  // A pin must therefore hold its level for at least two cycles to be seen at all.
  // The delayed copies feed the edge detectors; after reset both copies are low, which
  // matches the idle level of every pin, so no false edge follows reset.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      filt       <= '0;
      filt_q     <= '0;
      ack_filt   <= '0;
      ack_filt_q <= '0;
    end else begin
      for (int i = 0; i < NI; i++) begin
        if (sync2[i] == sync3[i]) begin
          filt[i] <= sync3[i];
        end
      end
      for (int i = 0; i <= NL + NR + NT; i++) begin
        if (ack_sync2[i] == ack_sync3[i]) begin
          ack_filt[i] <= ack_sync3[i];
        end
      end
      filt_q     <= filt;
      ack_filt_q <= ack_filt;
    end
  end

  // Split the filtered vector back into named groups.
  // Index map: lamps from 0, then relays, telemetry, trip and alarm, then the lamp,
  // relay and telemetry group pins, with the panel key at the top.
  logic [NL-1:0] lamp_src;
  logic [NR-1:0] relay_src;
  logic [NT-1:0] telem_src;
  logic          trip_src;
  logic [NI-1:0] rise;
  logic [NL+NR+NT:0] ack_rise;

  assign lamp_src    = filt[NL-1:0];
  assign relay_src   = filt[NL+NR-1:NL];
  assign telem_src   = filt[NL+NR+NT-1:NL+NR];
  assign trip_src    = filt[NL+NR+NT];
  assign rise        = filt & ~filt_q;
  assign ack_rise    = ack_filt & ~ack_filt_q;

  // Output select shared by every item group: a latched item shows its latch or its source.
  // Keeping it in one place means the four groups cannot drift apart.
  function automatic logic held_level(input logic en, input logic lat, input logic src);
    return en ? (lat | src) : src;
  endfunction

  // Configuration registers written by software.
  // Unmapped and read-only offsets fall through the default branch, so stray writes are
  // harmless. Scope codes above the last defined one decode to no action at the key.
  logic [31:0] latch_en;
  logic [7:0]  auto_ack;
  logic        remote_en;
  key_scope_t  key_scope;
  ack_set_t    cmd_req;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      latch_en  <= LATCH_EN_RST;
      auto_ack  <= AUTO_ACK_RST;
      remote_en <= REMOTE_RST;
      key_scope <= key_scope_t'(KEY_SEL_RST);
    end else if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        REG_LATCH_EN: latch_en  <= reg_req_in.wdata;
        REG_AUTO_ACK: auto_ack  <= reg_req_in.wdata[7:0];
        REG_CONTROL: begin
          remote_en <= reg_req_in.wdata[CTL_REMOTE_POS];
          key_scope <= key_scope_t'(reg_req_in.wdata[CTL_KEY_LO +: 3]);
        end
        default: ;
      endcase
    end
  end

  // Collective commands arrive over the remote path and are one-cycle pulses.
  // A command is not stored, so one sent while a source is still high is lost, just as
  // an early acknowledge from a pin is.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cmd_req <= '0;
    end else if (reg_req_in.wr && reg_req_in.addr == REG_COMMAND) begin
      cmd_req.lamps  <= reg_req_in.wdata[CMD_LAMPS] | reg_req_in.wdata[CMD_ALL];
      cmd_req.relays <= reg_req_in.wdata[CMD_RELAY] | reg_req_in.wdata[CMD_ALL];
      cmd_req.telem  <= reg_req_in.wdata[CMD_TELEM] | reg_req_in.wdata[CMD_ALL];
      cmd_req.trip   <= reg_req_in.wdata[CMD_TRIP] | reg_req_in.wdata[CMD_ALL];
    end else begin
      cmd_req <= '0;
    end
  end

  // Panel key press maps to a collective acknowledge by the selected scope.
  // Scopes one and two act alike here, as no password check sits in this block.
  // The key path never looks at the remote enable: it is the one way to acknowledge
  // from the panel when remote acknowledge is switched off.
  ack_set_t key_ack;
  logic     key_rise;

  assign key_rise = rise[NI-1];

  always_comb begin
    key_ack = '0;
    if (key_rise) begin
      case (key_scope)
        KEY_LAMPS_FREE, KEY_LAMPS: key_ack.lamps = 1'b1;
        KEY_LAMPS_RLY: begin
          key_ack.lamps  = 1'b1;
          key_ack.relays = 1'b1;
        end
        KEY_ALL: key_ack = '1;
        default: key_ack = '0;
      endcase
    end
  end

  // Group requests: remote ones are gated by the enable, the key never is.
  // Automatic acknowledge counts as a non-panel type as well and is gated further below.
  ack_set_t grp;
  logic     alarm_rise;

  assign alarm_rise = rise[NL+NR+NT+1];

  always_comb begin
    grp        = key_ack;
    if (remote_en) begin
      grp.lamps  = grp.lamps | cmd_req.lamps | rise[NL+NR+NT+2];
      grp.relays = grp.relays | cmd_req.relays | rise[NL+NR+NT+3];
      grp.telem  = grp.telem | cmd_req.telem | rise[NL+NR+NT+4];
      grp.trip   = grp.trip | cmd_req.trip;
    end
  end

  // Per-item acknowledge vectors, individual inputs gated by the remote enable.
  // The automatic path is limited to lamps by construction; relays, telemetry and trip
  // have no alarm term at all.
  logic [NL-1:0] lamp_ack;
  logic [NR-1:0] relay_ack;
  logic [NT-1:0] telem_ack;
  logic          trip_ack;

  assign lamp_ack  = {NL{grp.lamps}} | (remote_en ? ack_rise[NL-1:0] : '0)
                   | ({NL{alarm_rise & remote_en}} & auto_ack[NL-1:0]);
  assign relay_ack = {NR{grp.relays}} | (remote_en ? ack_rise[NL+NR-1:NL] : '0);
  assign telem_ack = {NT{grp.telem}} | (remote_en ? ack_rise[NL+NR+NT-1:NL+NR] : '0);
  assign trip_ack  = grp.trip | (remote_en & ack_rise[NL+NR+NT]);

  // Latch state: set on rising source, cleared by ack only with source low.
  // An acknowledge that arrives while the source is still high is dropped, not stored;
  // the operator has to repeat it once the source has gone.
  // Every item latches here whatever its latching option; the option only decides
  // whether the output shows the latch, and the status words show the raw latches.
  logic [NL-1:0] lamp_lat;
  logic [NR-1:0] relay_lat;
  logic [NT-1:0] telem_lat;
  logic          trip_lat;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lamp_lat  <= '0;
      relay_lat <= '0;
      telem_lat <= '0;
      trip_lat  <= '0;
    end else begin
      // A rise in the same cycle as an ack wins because the source is then high.
      lamp_lat  <= (lamp_lat | lamp_src) & ~(lamp_ack & ~lamp_src);
      relay_lat <= (relay_lat | relay_src) & ~(relay_ack & ~relay_src);
      telem_lat <= (telem_lat | telem_src) & ~(telem_ack & ~telem_src);
      trip_lat  <= (trip_lat | trip_src) & ~(trip_ack & ~trip_src);
    end
  end

  // Relay off-delay timers, restarted whenever the relay's drive falls.
  // The timer reloads on every cycle of drive, so a relay is held for the full delay
  // after its last active cycle. The counter is sized by a package width; an off-delay
  // larger than that width can express would be cut short.
  logic [NR-1:0]         relay_drive;
  logic [OFF_CNT_W-1:0]  off_cnt [NR];
  logic [NR-1:0]         relay_hold;

  always_comb begin
    for (int i = 0; i < NR; i++) begin
      relay_drive[i] = held_level(latch_en[LEN_RELAY_POS + i], relay_lat[i],
                                  relay_src[i]);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      relay_hold <= '0;
      for (int i = 0; i < NR; i++) begin
        off_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NR; i++) begin
        if (relay_drive[i]) begin
          relay_hold[i] <= 1'b1;
          off_cnt[i]    <= OFF_CNT_W'(OFF_CYCLES);
        end else if (off_cnt[i] != '0) begin
          off_cnt[i] <= off_cnt[i] - 1'b1;
        end else begin
          relay_hold[i] <= 1'b0;
        end
      end
    end
  end

  // Output flops; latching option selects latch or plain follow per item.
  // Registering here keeps every output glitch-free while the latch terms settle.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lamp_out  <= '0;
      relay_out <= '0;
      telem_out <= '0;
      trip_out  <= 1'b0;
    end else begin
      for (int i = 0; i < NL; i++) begin
        lamp_out[i] <= held_level(latch_en[LEN_LAMP_POS + i], lamp_lat[i],
                                  lamp_src[i]);
      end
      for (int i = 0; i < NT; i++) begin
        telem_out[i] <= held_level(latch_en[LEN_TELEM_POS + i], telem_lat[i],
                                   telem_src[i]);
      end
      relay_out <= relay_hold;
      trip_out  <= held_level(latch_en[LEN_TRIP_POS], trip_lat,
                              trip_src);
    end
  end

  // Register read data, valid the cycle after the read strobe only.
  // Returning zero outside the slot keeps a shared read bus free of stale words.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        REG_LATCH_EN:   reg_rdata_out <= latch_en;
        REG_AUTO_ACK:   reg_rdata_out <= {24'h0, auto_ack};
        REG_CONTROL:    reg_rdata_out <= {25'h0, key_scope, 3'h0, remote_en};
        REG_LAMP_STAT:  reg_rdata_out <= 32'(lamp_lat);
        REG_RELAY_STAT: reg_rdata_out <= 32'(relay_lat);
        REG_TELEM_STAT: reg_rdata_out <= 32'(telem_lat);
        REG_TRIP_STAT:  reg_rdata_out <= {31'h0, trip_lat};
        default:        reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule

`default_nettype wire

// >>> latch_ack_chk.sv
// Checker for the latch and acknowledge manager, bound to its top module.
// Assumes one clock and the synchronous active-high reset of the design.
`timescale 1ns/1ps
`default_nettype none
module latch_ack_chk
  import latch_ack_pkg::*;
#(
  parameter int NL         = 8,
  parameter int NR         = 8,
  parameter int NT         = 8,
  parameter int OFF_CYCLES = 20
) (
  input wire logic                    core_clk_in,
  input wire logic                    sys_rst_in,
  input wire latch_ack_pkg::reg_req_t reg_req_in,
  input wire logic [31:0]             reg_rdata_out,
  input wire logic [NL-1:0]           lamp_src_in,
  input wire logic [NR-1:0]           relay_src_in,
  input wire logic                    trip_src_in,
  input wire logic [NL-1:0]           lamp_out,
  input wire logic [NR-1:0]           relay_out,
  input wire logic [NT-1:0]           telem_out,
  input wire logic                    trip_out
);
  logic [7:0]  lamp_hist;
  logic [7:0]  trip_hist;
  logic [15:0] relay_low;
  // Source history lets a rising output be traced to a recent cause.
  always_ff @(posedge core_clk_in) begin
    lamp_hist <= {lamp_hist[6:0], lamp_src_in[0]};
    trip_hist <= {trip_hist[6:0], trip_src_in};
  end
  // Low time of relay source 0; it saturates so a long idle never wraps.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || relay_src_in[0])
      relay_low <= 16'h0000;
    else if (relay_low != 16'hffff)
      relay_low <= relay_low + 16'h0001;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_rdata_idle_zero: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero outside its slot");
  a_reset_clears_outputs: assert property (disable iff (1'b0) sys_rst_in |=>
    lamp_out == '0 && relay_out == '0 && telem_out == '0 && !trip_out)
    else $error("outputs not cleared by reset");
  a_lamp_held_on: assert property (lamp_src_in[0] [*8] |=> lamp_out[0])
    else $error("lamp off while source held high");
  a_trip_held_on: assert property (trip_src_in [*8] |=> trip_out)
    else $error("trip off while source held high");
  a_lamp_rise_cause: assert property ($rose(lamp_out[0]) |-> |lamp_hist)
    else $error("lamp rose without a source");
  a_trip_rise_cause: assert property ($rose(trip_out) |-> |trip_hist)
    else $error("trip rose without a source");
  a_lamp_clear_low: assert property (!$past(sys_rst_in) && $fell(lamp_out[0])
    |-> !(&lamp_hist)) else $error("lamp cleared while source high");
  a_relay_off_wait: assert property (!$past(sys_rst_in) && $fell(relay_out[0])
    |-> relay_low >= OFF_CYCLES) else $error("relay dropped before off-delay");
  c_lamp_latched: cover property (lamp_out[0] && !lamp_src_in[0]);
  c_relay_drop: cover property ($fell(relay_out[0]));
  c_trip_clear: cover property ($fell(trip_out));
endmodule
bind latch_acknowledge_manager latch_ack_chk #(
  .NL(NL), .NR(NR), .NT(NT), .OFF_CYCLES(OFF_CYCLES)
) chk_u (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .lamp_src_in(lamp_src_in), .relay_src_in(relay_src_in),
  .trip_src_in(trip_src_in), .lamp_out(lamp_out), .relay_out(relay_out),
  .telem_out(telem_out), .trip_out(trip_out)
);
`default_nettype wire

// >>> far_side_model.sv
// Model of the protection sources and acknowledge pins around the manager.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic        clk_in,
  output logic [24:0]      src_out,
  output logic [29:0]      pin_out
);
  // Everything idles low; sources are driven levels, so a dropped one reads low.
  initial begin
    src_out = '0;
    pin_out = '0;
  end
  // Source levels change just after an edge and then settle through the filters.
  task automatic set_src(input logic [24:0] v);
    @(posedge clk_in);
    src_out <= v;
    repeat (11) @(posedge clk_in);
  endtask
  // An acknowledge is an edge event; the level is kept past the filter depth.
  task automatic pulse(input int b);
    @(posedge clk_in);
    pin_out[b] <= 1'b1;
    repeat (4) @(posedge clk_in);
    pin_out[b] <= 1'b0;
    repeat (16) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> latch_acknowledge_manager_bench.sv
// Self-checking bench for the latch and acknowledge manager.
// Assumes the far side model drives all source and acknowledge pins.
`timescale 1ns/1ps
`default_nettype none
module latch_acknowledge_manager_bench;
  import latch_ack_pkg::*;
  localparam int OFF = 4;
  logic        core_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  reg_req_t    req = '0;
  logic [31:0] rdata;
  logic [24:0] src;
  logic [29:0] pin;
  logic [7:0]  lamp;
  logic [7:0]  relay;
  logic [7:0]  telem;
  logic        trip;
  int          errors = 0;
  int          check_count = 0;
  // Free-running 200 MHz clock.
  always #2.5 core_clk_in = ~core_clk_in;
  far_side_model far_u (.clk_in(core_clk_in), .src_out(src), .pin_out(pin));
  // A short off-delay keeps the relay cases quick.
  latch_acknowledge_manager #(.OFF_CYCLES(OFF)) dut_u (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .lamp_src_in(src[7:0]), .relay_src_in(src[15:8]),
    .telem_src_in(src[23:16]), .trip_src_in(src[24]), .prot_alarm_in(pin[29]),
    .lamp_ack_in(pin[7:0]), .relay_ack_in(pin[15:8]), .telem_ack_in(pin[23:16]),
    .trip_command_ack_input_in(pin[24]), .lamp_group_ack_input_in(pin[25]),
    .relay_group_ack_input_in(pin[26]), .telem_group_ack_input_in(pin[27]),
    .panel_key_in(pin[28]), .lamp_out(lamp), .relay_out(relay), .telem_out(telem),
    .trip_out(trip)
  );
  task automatic end_sim();
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Item 0 of each group packed as lamp, relay, telemetry, trip.
  function automatic logic [31:0] o4();
    return {28'h0000000, lamp[0], relay[0], telem[0], trip};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk_in);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask
  task automatic latch_all();
    far_u.set_src('1);
    far_u.set_src('0);
  endtask
  task automatic t_reset();
    rd(REG_LATCH_EN, 32'h0);
    rd(REG_AUTO_ACK, 32'h0);
    rd(REG_CONTROL, 32'h10);
    rd(8'h20, 32'h0);
    @(posedge core_clk_in);
    #1 check("rdata after slot", rdata, 32'h0);
  endtask
  task automatic t_latch();
    wr(REG_LATCH_EN, 32'h01010105);
    far_u.set_src('1);
    check("lamps on", {24'h0, lamp}, 32'hff);
    far_u.set_src('0);
    repeat (8) @(posedge core_clk_in);
    check("lamps kept", {24'h0, lamp}, 32'h05);
    check("items kept", o4(), 32'hf);
  endtask
  // With remote acknowledge off, individual and group pins and commands are all ignored.
  task automatic t_remote_off();
    int p[7] = '{25, 0, 26, 27, 24, 8, 16};
    foreach (p[i]) far_u.pulse(p[i]);
    wr(REG_COMMAND, 32'h1f);
    repeat (16) @(posedge core_clk_in);
    check("remote off", o4(), 32'hf);
  endtask
  task automatic t_key();
    logic [3:0] ks[5] = '{4'hf, 4'h7, 4'h7, 4'h3, 4'h0};
    for (int s = 0; s < 5; s++) begin
      wr(REG_CONTROL, 32'(s) << 4);
      latch_all();
      far_u.pulse(28);
      check("key scope", o4(), {28'h0, ks[s]});
    end
  endtask
  task automatic t_src_high();
    wr(REG_CONTROL, 32'h01);
    far_u.set_src(25'h0000001);
    far_u.pulse(25);
    check("ack while high", o4() >> 3, 32'h1);
    far_u.set_src('0);
    check("ack forgotten", o4() >> 3, 32'h1);
    far_u.pulse(25);
    check("lamp group", {24'h0, lamp}, 32'h0);
  endtask
  task automatic t_indiv();
    latch_all();
    far_u.pulse(2);
    far_u.pulse(24);
    far_u.pulse(8);
    check("one lamp", {24'h0, lamp}, 32'h01);
    check("one each", o4(), 32'ha);
    rd(REG_LAMP_STAT, 32'hfb);
    rd(REG_RELAY_STAT, 32'hfe);
    for (int b = 1; b < 24; b++) begin
      if (b != 2 && b != 8 && b != 16) begin
        far_u.pulse(b);
      end
    end
    rd(REG_LAMP_STAT, 32'h01);
    rd(REG_RELAY_STAT, 32'h0);
    rd(REG_TELEM_STAT, 32'h01);
    rd(REG_TRIP_STAT, 32'h0);
  endtask
  task automatic t_auto();
    wr(REG_AUTO_ACK, 32'h1);
    wr(REG_CONTROL, 32'h0);
    latch_all();
    far_u.pulse(29);
    check("auto blocked", {24'h0, lamp}, 32'h05);
    wr(REG_CONTROL, 32'h1);
    far_u.pulse(29);
    check("auto lamps", {24'h0, lamp}, 32'h04);
    check("auto others", o4(), 32'h7);
  endtask
  // The relay must stay on for at least OFF + 2 cycles, counted from the start of the group acknowledge pulse.
  task automatic t_group();
    int n;
    latch_all();
    fork
      far_u.pulse(26);
      begin
        n = 0;
        while (relay[0] === 1'b1 && n < 60) begin
          @(posedge core_clk_in);
          n++;
        end
        if (n >= 60) begin
          errors++;
          end_sim();
        end
      end
    join
    check("relay delay", {31'h0, n >= OFF + 2}, 32'h1);
    far_u.pulse(27);
    check("groups", o4(), 32'h9);
  endtask
  task automatic t_cmds();
    logic [3:0] ce[5] = '{4'h7, 4'hb, 4'hd, 4'he, 4'h0};
    for (int i = 0; i < 5; i++) begin
      latch_all();
      wr(REG_COMMAND, 32'h1 << i);
      repeat (16) @(posedge core_clk_in);
      check("command", o4(), {28'h0, ce[i]});
    end
  endtask
  // Reset for 20 cycles, then each scenario in turn.
  initial begin
    repeat (20) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_latch();
    t_remote_off();
    t_key();
    t_src_high();
    t_indiv();
    t_auto();
    t_group();
    t_cmds();
    end_sim();
  end
endmodule
`default_nettype wire
